//--- src/charger_flags_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CHARGER_FLAGS_PARAMS_SVH
`define CHARGER_FLAGS_PARAMS_SVH

`define OFS_CHARGER_EVENT_FLAGS      8'h03
`define OFS_SUPPLY_THERMAL_FLAGS     8'h04
`define OFS_THERMISTOR_OPEN_FLAGS    8'h05
`define OFS_TIMER_FAULT_FLAGS        8'h06
`define OFS_CHARGER_EVENT_MASKS      8'h07

`define RST_FLAGS                    8'h00
`define RST_CHARGER_EVENT_MASKS      8'h00
`define RST_READ_DATA                8'h00

// Defined (settable) bits of each flag register
`define DEF_CHARGER_EVENT_FLAGS      8'h77
`define DEF_SUPPLY_THERMAL_FLAGS     8'hBF
`define DEF_THERMISTOR_OPEN_FLAGS    8'h01
`define DEF_TIMER_FAULT_FLAGS        8'h77

// Field positions
`define BIT_INPUT_OVERVOLTAGE        7
`define BIT_BATTERY_OVERCURRENT      5
`define BIT_BATTERY_UNDERVOLTAGE     4
`define BIT_THERMISTOR_COLD          3
`define BIT_THERMISTOR_COOL          2
`define BIT_THERMISTOR_WARM          1
`define BIT_THERMISTOR_HOT           0
`define BIT_THERMISTOR_OPEN          0
`define BIT_WATCHDOG_EXPIRY          6
`define BIT_CHARGE_SAFETY_EXPIRY     5
`define BIT_REGULATOR_OVERCURRENT    4
`define BIT_BUTTON_WAKE_FIRST        2
`define BIT_BUTTON_WAKE_SECOND       1
`define BIT_BUTTON_RESET_WARNING     0
`define BIT_CONSTANT_VOLTAGE_ENTRY   6
`define BIT_CHARGE_DONE              5
`define BIT_INPUT_CURRENT_LIMIT      4
`define BIT_INPUT_VOLTAGE_REGULATION 2
`define BIT_THERMAL_REGULATION       1
`define BIT_INPUT_POWER_GOOD         0

// Edge that sets each flag: rising, falling or both
`define RISE_CHARGER_EVENT_FLAGS     8'h77
`define FALL_CHARGER_EVENT_FLAGS     8'h01
`define RISE_SUPPLY_THERMAL_FLAGS    8'hAF
`define FALL_SUPPLY_THERMAL_FLAGS    8'h10
`define RISE_THERMISTOR_OPEN_FLAGS   8'h01
`define FALL_THERMISTOR_OPEN_FLAGS   8'h00
`define RISE_TIMER_FAULT_FLAGS       8'h77
`define FALL_TIMER_FAULT_FLAGS       8'h00

// Clock edges after reset until synchronised levels are settled
`define BOOT_SETTLE_CYCLES           3'd5

`endif

//--- src/charger_flags_pkg.sv
// Types shared by the charger event flag bank
package charger_flags_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_CHARGER  = 3'h1,
    SEL_SUPPLY   = 3'h3,
    SEL_OPEN     = 3'h2,
    SEL_TIMER    = 3'h6,
    SEL_MASK     = 3'h7
  } reg_sel_t;

endpackage : charger_flags_pkg

//--- src/sticky_flag_byte.sv
// One byte of synchronised, edge-detected, clear-on-read event flags
`timescale 1ns/1ps

module sticky_flag_byte
  import charger_flags_pkg::*;
#(
  parameter reg_byte_t DEFINED = 8'hFF,
  parameter reg_byte_t RISE    = 8'hFF,
  parameter reg_byte_t FALL    = 8'h00
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire reg_byte_t level_i,
  input  wire logic      clear_i,
  output reg_byte_t      flags_o,
  output reg_byte_t      level_o,
  output reg_byte_t      set_o
);

  reg_byte_t sync_1;
  reg_byte_t sync_2;
  reg_byte_t sync_3;
  reg_byte_t next_level;

  // Detector outputs are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_1 <= 8'h00;
      sync_2 <= 8'h00;
      sync_3 <= 8'h00;
    end else begin
      sync_1 <= level_i;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // A change counts only once stages two and three agree
  assign next_level = (sync_2 & sync_3) | (level_o & (sync_2 | sync_3));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 8'h00;
    end else begin
      level_o <= next_level;
    end
  end

  // Reserved bits never set, so they read as zero
  assign set_o = DEFINED & ((RISE & next_level & ~level_o) |
                            (FALL & ~next_level & level_o));

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o <= 8'h00;
    end else begin
      flags_o <= (flags_o & ~{8{clear_i}}) | set_o;
    end
  end

endmodule : sticky_flag_byte

//--- src/charger_event_flag_mask_bank.sv
// Charger event flag bank with charger mask register and interrupt request
`timescale 1ns/1ps
`include "charger_flags_params.svh"

module charger_event_flag_mask_bank
  import charger_flags_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire reg_byte_t reg_addr_i,
  input  wire logic      reg_rd_i,
  input  wire logic      reg_wr_i,
  input  wire reg_byte_t reg_wdata_i,
  output reg_byte_t      reg_rdata_o,
  input  wire logic      constant_voltage_entry_i,
  input  wire logic      charge_done_i,
  input  wire logic      input_current_limit_i,
  input  wire logic      input_voltage_regulation_i,
  input  wire logic      thermal_regulation_i,
  input  wire logic      input_power_good_i,
  input  wire logic      input_overvoltage_event_i,
  input  wire logic      battery_overcurrent_event_i,
  input  wire logic      battery_undervoltage_level_i,
  input  wire logic      thermistor_cold_entry_i,
  input  wire logic      thermistor_cool_entry_i,
  input  wire logic      thermistor_warm_entry_i,
  input  wire logic      thermistor_hot_entry_i,
  input  wire logic      thermistor_open_event_i,
  input  wire logic      watchdog_expiry_event_i,
  input  wire logic      charge_safety_expiry_event_i,
  input  wire logic      regulator_overcurrent_event_i,
  input  wire logic      button_wake_first_expiry_i,
  input  wire logic      button_wake_second_expiry_i,
  input  wire logic      button_reset_warning_expiry_i,
  input  wire reg_byte_t supply_thermal_masks_i,
  input  wire reg_byte_t thermistor_open_masks_i,
  input  wire reg_byte_t timer_fault_masks_i,
  output logic           irq_request_o
);

  reg_sel_t  sel;
  reg_byte_t charger_event_masks;
  reg_byte_t charger_level;
  reg_byte_t supply_level;
  reg_byte_t open_level;
  reg_byte_t timer_level;
  reg_byte_t charger_flags;
  reg_byte_t supply_thermal_fault_flags;
  reg_byte_t thermistor_open_flags;
  reg_byte_t timer_fault_flags;
  reg_byte_t charger_set;
  reg_byte_t supply_set;
  reg_byte_t open_set;
  reg_byte_t timer_set;
  reg_byte_t charger_raw;
  reg_byte_t supply_raw;
  reg_byte_t open_raw;
  reg_byte_t timer_raw;
  reg_byte_t next_rdata;
  reg_byte_t charger_pending;
  logic      other_pending;
  logic      next_irq;
  logic      boot_quiet;
  logic [2:0] boot_cnt;

  // Address decode
  always_comb begin
    case (reg_addr_i)
      `OFS_CHARGER_EVENT_FLAGS:   sel = SEL_CHARGER;
      `OFS_SUPPLY_THERMAL_FLAGS:  sel = SEL_SUPPLY;
      `OFS_THERMISTOR_OPEN_FLAGS: sel = SEL_OPEN;
      `OFS_TIMER_FAULT_FLAGS:     sel = SEL_TIMER;
      `OFS_CHARGER_EVENT_MASKS:   sel = SEL_MASK;
      default:                    sel = SEL_NONE;
    endcase
  end

  // Detector levels into each flag byte
  always_comb begin
    charger_raw = 8'h00;
    charger_raw[`BIT_CONSTANT_VOLTAGE_ENTRY]   = constant_voltage_entry_i;
    charger_raw[`BIT_CHARGE_DONE]              = charge_done_i;
    charger_raw[`BIT_INPUT_CURRENT_LIMIT]      = input_current_limit_i;
    charger_raw[`BIT_INPUT_VOLTAGE_REGULATION] = input_voltage_regulation_i;
    charger_raw[`BIT_THERMAL_REGULATION]       = thermal_regulation_i;
    charger_raw[`BIT_INPUT_POWER_GOOD]         = input_power_good_i;
    supply_raw = 8'h00;
    supply_raw[`BIT_INPUT_OVERVOLTAGE]    = input_overvoltage_event_i;
    supply_raw[`BIT_BATTERY_OVERCURRENT]  = battery_overcurrent_event_i;
    supply_raw[`BIT_BATTERY_UNDERVOLTAGE] = battery_undervoltage_level_i;
    supply_raw[`BIT_THERMISTOR_COLD]      = thermistor_cold_entry_i;
    supply_raw[`BIT_THERMISTOR_COOL]      = thermistor_cool_entry_i;
    supply_raw[`BIT_THERMISTOR_WARM]      = thermistor_warm_entry_i;
    supply_raw[`BIT_THERMISTOR_HOT]       = thermistor_hot_entry_i;
    open_raw = 8'h00;
    open_raw[`BIT_THERMISTOR_OPEN] = thermistor_open_event_i;
    timer_raw = 8'h00;
    timer_raw[`BIT_WATCHDOG_EXPIRY]       = watchdog_expiry_event_i;
    timer_raw[`BIT_CHARGE_SAFETY_EXPIRY]  = charge_safety_expiry_event_i;
    timer_raw[`BIT_REGULATOR_OVERCURRENT] = regulator_overcurrent_event_i;
    timer_raw[`BIT_BUTTON_WAKE_FIRST]     = button_wake_first_expiry_i;
    timer_raw[`BIT_BUTTON_WAKE_SECOND]    = button_wake_second_expiry_i;
    timer_raw[`BIT_BUTTON_RESET_WARNING]  = button_reset_warning_expiry_i;
  end

  // Power-good flags on any change, other charger events on entry
  sticky_flag_byte #(
    .DEFINED (`DEF_CHARGER_EVENT_FLAGS),
    .RISE    (`RISE_CHARGER_EVENT_FLAGS),
    .FALL    (`FALL_CHARGER_EVENT_FLAGS)
  ) u_charger (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (charger_raw),
    .clear_i (reg_rd_i && sel == SEL_CHARGER),
    .flags_o (charger_flags),
    .level_o (charger_level),
    .set_o   (charger_set)
  );

  // Undervoltage flag sets on recovery: one means it is below, so it sets on the fall
  sticky_flag_byte #(
    .DEFINED (`DEF_SUPPLY_THERMAL_FLAGS),
    .RISE    (`RISE_SUPPLY_THERMAL_FLAGS),
    .FALL    (`FALL_SUPPLY_THERMAL_FLAGS)
  ) u_supply (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (supply_raw),
    .clear_i (reg_rd_i && sel == SEL_SUPPLY),
    .flags_o (supply_thermal_fault_flags),
    .level_o (supply_level),
    .set_o   (supply_set)
  );

  sticky_flag_byte #(
    .DEFINED (`DEF_THERMISTOR_OPEN_FLAGS),
    .RISE    (`RISE_THERMISTOR_OPEN_FLAGS),
    .FALL    (`FALL_THERMISTOR_OPEN_FLAGS)
  ) u_open (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (open_raw),
    .clear_i (reg_rd_i && sel == SEL_OPEN),
    .flags_o (thermistor_open_flags),
    .level_o (open_level),
    .set_o   (open_set)
  );

  sticky_flag_byte #(
    .DEFINED (`DEF_TIMER_FAULT_FLAGS),
    .RISE    (`RISE_TIMER_FAULT_FLAGS),
    .FALL    (`FALL_TIMER_FAULT_FLAGS)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (timer_raw),
    .clear_i (reg_rd_i && sel == SEL_TIMER),
    .flags_o (timer_fault_flags),
    .level_o (timer_level),
    .set_o   (timer_set)
  );

  // All eight mask bits stored, reserved ones included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charger_event_masks <= `RST_CHARGER_EVENT_MASKS;
    end else if (reg_wr_i && sel == SEL_MASK) begin
      charger_event_masks <= reg_wdata_i;
    end
  end

  // Read data is the value before the clear takes effect
  always_comb begin
    case (sel)
      SEL_CHARGER: next_rdata = charger_flags;
      SEL_SUPPLY:  next_rdata = supply_thermal_fault_flags;
      SEL_OPEN:    next_rdata = thermistor_open_flags;
      SEL_TIMER:   next_rdata = timer_fault_flags;
      SEL_MASK:    next_rdata = charger_event_masks;
      default:     next_rdata = `RST_READ_DATA;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `RST_READ_DATA;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Synchroniser latency hides the power-up state; wait it out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_cnt <= 3'd0;
    end else if (boot_cnt != `BOOT_SETTLE_CYCLES) begin
      boot_cnt <= boot_cnt + 3'd1;
    end
  end

  // Quiet held only if power was good and battery low at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_quiet <= 1'b1;
    end else if (reg_rd_i && sel == SEL_CHARGER) begin
      boot_quiet <= 1'b0;
    end else if (boot_cnt == `BOOT_SETTLE_CYCLES && boot_quiet &&
                 !(charger_level[`BIT_INPUT_POWER_GOOD] &&
                   supply_level[`BIT_BATTERY_UNDERVOLTAGE])) begin
      boot_quiet <= 1'b0;
    end
  end

  always_comb begin
    charger_pending = charger_flags & ~charger_event_masks;
    if (boot_quiet) begin
      charger_pending[`BIT_INPUT_POWER_GOOD] = 1'b0;
    end
    other_pending = |(supply_thermal_fault_flags & ~supply_thermal_masks_i) |
                    |(thermistor_open_flags & ~thermistor_open_masks_i) |
                    |(timer_fault_flags & ~timer_fault_masks_i);
    next_irq = (|charger_pending) | other_pending;
  end

  // Level request while an unmasked flag is pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_request_o <= 1'b0;
    end else begin
      irq_request_o <= next_irq;
    end
  end

  mask_reset_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> charger_event_masks == 8'h00)
    else $error("mask not zero after reset");

  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h07 |=>
    charger_event_masks == $past(reg_wdata_i))
    else $error("mask write lost");

  ovp_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_thermal_fault_flags[7] &&
    !(reg_rd_i && reg_addr_i == 8'h04) |=>
    supply_thermal_fault_flags[7])
    else $error("overvoltage flag dropped without read");

  ovp_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(input_overvoltage_event_i) ##1 input_overvoltage_event_i [*3]
    |-> ##1 supply_thermal_fault_flags[7])
    else $error("overvoltage not flagged");

  fault_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_thermal_fault_flags[6] &&
    thermistor_open_flags[7:1] == 7'h00)
    else $error("reserved flag bit set");

  // A set on the rising side would flag the drop instead of the recovery
  uvlo_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_set[4] |-> supply_level[4]
    ##1 !supply_level[4] && supply_thermal_fault_flags[4])
    else $error("undervoltage flag encoding wrong");

  open_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 8'h05 && open_set == 8'h00 |=>
    thermistor_open_flags == 8'h00)
    else $error("open flags not cleared by read");

  timer_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 8'h06 |=>
    reg_rdata_o == $past(timer_fault_flags))
    else $error("timer flag read data wrong");

  timer_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !timer_fault_flags[7] && !timer_fault_flags[3])
    else $error("reserved timer flag bit set");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 8'h06 && timer_set[6] |=>
    timer_fault_flags[6])
    else $error("event lost during clearing read");

  irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (charger_flags[5] && !charger_event_masks[5]) |=> irq_request_o)
    else $error("unmasked flag gave no request");

  pg_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_quiet && !other_pending &&
    (charger_flags & ~charger_event_masks & 8'hFE) == 8'h00
    |=> !irq_request_o)
    else $error("power-good request at power-up");

  chg_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((charger_flags | charger_set) & 8'h88) == 8'h00)
    else $error("reserved charger flag bit set");

  // Power-good reports both edges, so a lost fall would hide an unplug
  pg_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    charger_level[0] != $past(charger_level[0]) |->
    charger_flags[0])
    else $error("power-good change not flagged");

  open_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(open_level[0]) |-> thermistor_open_flags[0])
    else $error("thermistor open not flagged");

  safety_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(timer_level[5]) |-> timer_fault_flags[5])
    else $error("safety timer expiry not flagged");

  ovp_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
    supply_thermal_fault_flags[7] && reg_rd_i && reg_addr_i == 8'h04);

  mask_irq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    charger_flags[6] && charger_event_masks[6] && !irq_request_o);

  set_clear_c: cover property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 8'h06 && timer_set != 8'h00);

  boot_quiet_c: cover property (@(posedge clk_i) disable iff (rst_i)
    boot_quiet && boot_cnt == 3'd5 && charger_flags[0]);

endmodule : charger_event_flag_mask_bank

//--- tb/host_reg_model.sv
// Host side model: byte reads and writes on the register strobe port
`timescale 1ns/1ps

module host_reg_model
  import charger_flags_pkg::*;
(
  input  wire logic      clk_i,
  output reg_byte_t      reg_addr_o,
  output logic           reg_rd_o,
  output logic           reg_wr_o,
  output reg_byte_t      reg_wdata_o,
  input  wire reg_byte_t reg_rdata_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // The read itself clears the flags, so its data is the only record
  task automatic read_reg(input reg_byte_t addr, output reg_byte_t data);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask : read_reg

  // Data is inverted once the strobe drops so stale values never match
  task automatic write_reg(input reg_byte_t addr, input reg_byte_t data);
    @(negedge clk_i);
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : write_reg
endmodule : host_reg_model

//--- tb/charger_event_flag_mask_bank_tb_top.sv
// Testbench for the charger event flag and mask bank
`timescale 1ns/1ps

module charger_event_flag_mask_bank_tb_top
  import charger_flags_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic [19:0] ev;
  reg_byte_t   st_m;
  reg_byte_t   op_m;
  reg_byte_t   tm_m;
  reg_byte_t   addr;
  reg_byte_t   rdata;
  logic        rd;
  logic        wr_strobe;
  reg_byte_t   wdata;
  logic        irq;
  int          mismatches;
  int          samples_checked;
  int          ad [20] = '{3, 3, 3, 3, 3, 3, 4, 4, 4, 4,
                           4, 4, 4, 5, 6, 6, 6, 6, 6, 6};
  int          bt [20] = '{6, 5, 4, 2, 1, 0, 7, 5, 4, 3,
                           2, 1, 0, 0, 6, 5, 4, 2, 1, 0};
  int          sel [3] = '{6, 13, 14};

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  host_reg_model i_host_reg_model (
    .clk_i(clk_i), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr_strobe),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  charger_event_flag_mask_bank i_charger_event_flag_mask_bank (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr_strobe), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .constant_voltage_entry_i(ev[0]), .charge_done_i(ev[1]),
    .input_current_limit_i(ev[2]), .input_voltage_regulation_i(ev[3]),
    .thermal_regulation_i(ev[4]), .input_power_good_i(ev[5]),
    .input_overvoltage_event_i(ev[6]),
    .battery_overcurrent_event_i(ev[7]),
    .battery_undervoltage_level_i(ev[8]),
    .thermistor_cold_entry_i(ev[9]), .thermistor_cool_entry_i(ev[10]),
    .thermistor_warm_entry_i(ev[11]), .thermistor_hot_entry_i(ev[12]),
    .thermistor_open_event_i(ev[13]), .watchdog_expiry_event_i(ev[14]),
    .charge_safety_expiry_event_i(ev[15]),
    .regulator_overcurrent_event_i(ev[16]),
    .button_wake_first_expiry_i(ev[17]),
    .button_wake_second_expiry_i(ev[18]),
    .button_reset_warning_expiry_i(ev[19]),
    .supply_thermal_masks_i(st_m), .thermistor_open_masks_i(op_m),
    .timer_fault_masks_i(tm_m), .irq_request_o(irq));

  task automatic check(input reg_byte_t seen, input reg_byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input int a, input reg_byte_t exp);
    reg_byte_t d;
    i_host_reg_model.read_reg(reg_byte_t'(a), d);
    check(d, exp);
  endtask : rd_chk

  task automatic wr(input int a, input reg_byte_t d);
    i_host_reg_model.write_reg(reg_byte_t'(a), d);
  endtask : wr

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n

  // Rise then fall of one detector; undervoltage sets only on recovery
  task automatic pulse_event(input int i);
    reg_byte_t bitv;
    bitv = 8'h01 << bt[i];
    ev[i] = 1'b1;
    wait_n(6);
    check({7'h00, irq}, (i == 8) ? 8'h00 : 8'h01);
    rd_chk(ad[i], (i == 8) ? 8'h00 : bitv);
    ev[i] = 1'b0;
    wait_n(6);
    rd_chk(ad[i], (i == 5 || i == 8) ? bitv : 8'h00);
    rd_chk(ad[i], 8'h00);
    wait_n(1);
    check({7'h00, irq}, 8'h00);
  endtask : pulse_event

  task automatic summarize;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end

  initial begin
    reg_byte_t r1;
    reg_byte_t r2;
    mismatches      = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    ev    = '0;
    st_m  = 8'h00;
    op_m  = 8'h00;
    tm_m  = 8'h00;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    wait_n(6);
    for (int a = 3; a <= 7; a++) rd_chk(a, 8'h00);
    rd_chk(16, 8'h00);
    wr(7, 8'hFF);
    rd_chk(7, 8'hFF);
    wr(6, 8'hFF);
    rd_chk(6, 8'h00);
    wr(7, 8'h00);
    for (int i = 0; i < 20; i++) pulse_event(i);
    // Masked power-good still latches but stays silent
    wr(7, 8'h01);
    ev[5] = 1'b1;
    wait_n(6);
    check({7'h00, irq}, 8'h00);
    rd_chk(3, 8'h01);
    ev[5] = 1'b0;
    wait_n(6);
    rd_chk(3, 8'h01);
    wr(7, 8'h00);
    ev[0] = 1'b1;
    wait_n(6);
    check({7'h00, irq}, 8'h01);
    wr(7, 8'h40);
    wait_n(1);
    check({7'h00, irq}, 8'h00);
    rd_chk(3, 8'h40);
    wr(7, 8'h00);
    ev[0] = 1'b0;
    // Masks of the other groups arrive as inputs
    st_m = 8'hFF;
    op_m = 8'hFF;
    tm_m = 8'hFF;
    for (int k = 0; k < 3; k++) begin
      ev[sel[k]] = 1'b1;
      wait_n(6);
      check({7'h00, irq}, 8'h00);
      rd_chk(ad[sel[k]], 8'h01 << bt[sel[k]]);
      ev[sel[k]] = 1'b0;
      wait_n(6);
    end
    st_m = 8'h00;
    op_m = 8'h00;
    tm_m = 8'h00;
    // Reads land on the setting edge in one of the two offsets
    for (int d = 2; d <= 3; d++) begin
      ev[14] = 1'b1;
      wait_n(d);
      i_host_reg_model.read_reg(8'h06, r1);
      i_host_reg_model.read_reg(8'h06, r2);
      check(r1 | r2, 8'h40);
      ev[14] = 1'b0;
      wait_n(6);
      rd_chk(6, 8'h00);
    end
    // Power-up with input good and battery below level
    rst_i = 1'b1;
    ev[5] = 1'b1;
    ev[8] = 1'b1;
    wait_n(3);
    rst_i = 1'b0;
    wait_n(12);
    check({7'h00, irq}, 8'h00);
    rd_chk(3, 8'h01);
    wait_n(1);
    check({7'h00, irq}, 8'h00);
    summarize();
  end
endmodule : charger_event_flag_mask_bank_tb_top
